/* File: hdl/iism_merge.v */
// How it works
// - Only IRQ 3, 4, 5, 7, 9, 10, 11 and 15 can be fed from gpio pins.
// - A gpio pin set to its irq function drives its slot when no internal device claims it.
// - An activated device with that irq selected and enabled blocks the gpio irq.
// - An activated device with that irq selected but not enabled lets the gpio irq through.
// - A device that is not activated never counts as enabled.
// - Floppy, three uarts and parallel port use their own enable bit.
// - Keyboard, mouse, midi and watchdog count as enabled when a nonzero irq is selected.
// - Those devices must also be activated to count as enabled.
`timescale 1ns/1ps
`default_nettype none
`include "iism_defs.vh"

module iism_merge (
	// clock and reset
	input  wire        sys_clk_in,
	input  wire        rstn_in,
	// gpio irq inputs, one per slot; only supported slots are used
	input  wire [15:0] gpio_irq_in,
	input  wire [15:0] gpio_irq_func_in,
	// floppy_controller
	input  wire [3:0]  floppy_irq_sel_in,
	input  wire        floppy_act_in,
	input  wire        floppy_irq_en_in,
	input  wire        floppy_irq_in,
	// uarts
	input  wire [3:0]  uart1_irq_sel_in,
	input  wire        uart1_act_in,
	input  wire        uart1_irq_en_in,
	input  wire        uart1_irq_in,
	input  wire [3:0]  uart2_irq_sel_in,
	input  wire        uart2_act_in,
	input  wire        uart2_irq_en_in,
	input  wire        uart2_irq_in,
	input  wire [3:0]  uart3_irq_sel_in,
	input  wire        uart3_act_in,
	input  wire        uart3_irq_en_in,
	input  wire        uart3_irq_in,
	// parallel port
	input  wire [3:0]  par_irq_sel_in,
	input  wire        par_act_in,
	input  wire        par_irq_en_in,
	input  wire        par_irq_in,
	// keyboard and mouse share one activate
	input  wire [3:0]  kbd_irq_sel_in,
	input  wire [3:0]  mouse_irq_sel_in,
	input  wire        kbd_act_in,
	input  wire        kbd_irq_in,
	input  wire        mouse_irq_in,
	// midi_interface_device
	input  wire [3:0]  midi_irq_sel_in,
	input  wire        midi_act_in,
	input  wire        midi_irq_in,
	// watchdog, irq from watchdog_irq_config
	input  wire [3:0]  watchdog_irq_config_in,
	input  wire        wdog_act_in,
	input  wire        wdog_irq_in,
	// serial irq frame slot levels and status
	output reg  [15:0] slot_level_out,
	output reg  [15:0] slot_claimed_out,
	output reg  [15:0] slot_ext_out
);

	// synchronised gpio levels
	wire [15:0] gpio_sync;
	// effective enable of each source, activate folded in
	reg         floppy_on;
	reg         uart1_on;
	reg         uart2_on;
	reg         uart3_on;
	reg         par_on;
	reg         kbd_on;
	reg         mouse_on;
	reg         midi_on;
	reg         wdog_on;
	// slot claimed by each source
	reg  [15:0] floppy_claim;
	reg  [15:0] uart1_claim;
	reg  [15:0] uart2_claim;
	reg  [15:0] uart3_claim;
	reg  [15:0] par_claim;
	reg  [15:0] kbd_claim;
	reg  [15:0] mouse_claim;
	reg  [15:0] midi_claim;
	reg  [15:0] wdog_claim;
	// slot level driven by each source
	reg  [15:0] floppy_drive;
	reg  [15:0] uart1_drive;
	reg  [15:0] uart2_drive;
	reg  [15:0] uart3_drive;
	reg  [15:0] par_drive;
	reg  [15:0] kbd_drive;
	reg  [15:0] mouse_drive;
	reg  [15:0] midi_drive;
	reg  [15:0] wdog_drive;
	// merged slot values before the output register
	reg  [15:0] next_claimed;
	reg  [15:0] next_int_level;
	reg  [15:0] next_ext;
	reg  [15:0] next_level;

	// one-hot slot from an irq select; none gives no slot
	function [15:0] iism_slot;
		input [3:0] sel;
		begin
			if (sel == `IISM_IRQ_NONE)
				iism_slot = 16'h0000;
			else
				iism_slot = 16'h0001 << sel;
		end
	endfunction

	// devices without an enable bit count as enabled once an irq is set
	function iism_sel_set;
		input [3:0] sel;
		begin
			iism_sel_set = (sel != `IISM_IRQ_NONE);
		end
	endfunction

	// level a source puts on its claimed slot
	function [15:0] iism_drive;
		input [15:0] claim;
		input        irq;
		begin
			if (irq)
				iism_drive = claim;
			else
				iism_drive = 16'h0000;
		end
	endfunction

	// slot of a source that is switched on; none otherwise
	function [15:0] iism_claim;
		input [3:0] sel;
		input       on;
		begin
			if (on)
				iism_claim = iism_slot(sel);
			else
				iism_claim = 16'h0000;
		end
	endfunction

	// sync; gpio levels on slots claimed by a device are masked off below
	iism_sync u_sync (
		.sys_clk_in (sys_clk_in),
		.rstn_in    (rstn_in),
		.async_in   (gpio_irq_in),
		.sync_out   (gpio_sync)
	);

	// an inactive device never counts as enabled
	always @* begin
		floppy_on = floppy_act_in & floppy_irq_en_in;
		uart1_on  = uart1_act_in & uart1_irq_en_in;
		uart2_on  = uart2_act_in & uart2_irq_en_in;
		uart3_on  = uart3_act_in & uart3_irq_en_in;
		par_on    = par_act_in & par_irq_en_in;
		// no enable bit: a nonzero select enables, still gated by activate
		kbd_on    = kbd_act_in & iism_sel_set(kbd_irq_sel_in);
		mouse_on  = kbd_act_in & iism_sel_set(mouse_irq_sel_in);
		midi_on   = midi_act_in & iism_sel_set(midi_irq_sel_in);
		wdog_on   = wdog_act_in & iism_sel_set(watchdog_irq_config_in);
	end

	// an enabled source takes its slot; a disabled one leaves it free
	always @* begin
		floppy_claim = iism_claim(floppy_irq_sel_in, floppy_on);
		uart1_claim  = iism_claim(uart1_irq_sel_in, uart1_on);
		uart2_claim  = iism_claim(uart2_irq_sel_in, uart2_on);
		uart3_claim  = iism_claim(uart3_irq_sel_in, uart3_on);
		par_claim    = iism_claim(par_irq_sel_in, par_on);
		kbd_claim    = iism_claim(kbd_irq_sel_in, kbd_on);
		mouse_claim  = iism_claim(mouse_irq_sel_in, mouse_on);
		midi_claim   = iism_claim(midi_irq_sel_in, midi_on);
		wdog_claim   = iism_claim(watchdog_irq_config_in, wdog_on);
	end

	// idle or disabled sources put nothing on the slot
	always @* begin
		floppy_drive = iism_drive(floppy_claim, floppy_irq_in);
		uart1_drive  = iism_drive(uart1_claim, uart1_irq_in);
		uart2_drive  = iism_drive(uart2_claim, uart2_irq_in);
		uart3_drive  = iism_drive(uart3_claim, uart3_irq_in);
		par_drive    = iism_drive(par_claim, par_irq_in);
		kbd_drive    = iism_drive(kbd_claim, kbd_irq_in);
		mouse_drive  = iism_drive(mouse_claim, mouse_irq_in);
		midi_drive   = iism_drive(midi_claim, midi_irq_in);
		wdog_drive   = iism_drive(wdog_claim, wdog_irq_in);
	end

	// several sources on one slot are ored together
	always @* begin
		// a clash between devices is software's problem, not arbitrated here
		next_claimed   = floppy_claim | uart1_claim | uart2_claim | uart3_claim |
			par_claim | kbd_claim | mouse_claim | midi_claim | wdog_claim;
		next_int_level = floppy_drive | uart1_drive | uart2_drive | uart3_drive |
			par_drive | kbd_drive | mouse_drive | midi_drive | wdog_drive;
		// unsupported slots never take a gpio level
		// claimed slots shut the gpio path in the same cycle
		next_ext   = gpio_irq_func_in & `IISM_EXT_SLOT_MASK & ~next_claimed;
		next_level = next_int_level | (next_ext & gpio_sync);
	end

	// registered so the frame serialiser sees stable slots
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			slot_level_out   <= `IISM_SLOTS_RESET;
			slot_claimed_out <= `IISM_SLOTS_RESET;
			slot_ext_out     <= `IISM_SLOTS_RESET;
		end else begin
			slot_level_out   <= next_level;
			slot_claimed_out <= next_claimed;
			slot_ext_out     <= next_ext;
		end
	end

endmodule // iism_merge
`default_nettype wire

/* File: hdl/iism_defs.vh */
`ifndef IISM_DEFS_VH
`define IISM_DEFS_VH

// serial frame slots carried by this block (IRQ0..IRQ15)
`define IISM_NUM_SLOTS      16
// slots that may come from a gpio pin: 3,4,5,7,9,10,11,15
`define IISM_EXT_SLOT_MASK  16'h8EB8
// irq select code meaning no interrupt
`define IISM_IRQ_NONE       4'h0
// interrupt source indices
`define IISM_SRC_FLOPPY     0
`define IISM_SRC_UART1      1
`define IISM_SRC_UART2      2
`define IISM_SRC_UART3      3
`define IISM_SRC_PARALLEL   4
`define IISM_SRC_KBD        5
`define IISM_SRC_MOUSE      6
`define IISM_SRC_MIDI       7
`define IISM_SRC_WDOG       8
`define IISM_NUM_SRC        9
// sources 0..4 carry their own enable bit
`define IISM_NUM_EN_SRC     5
// reset value of the frame slots
`define IISM_SLOTS_RESET    16'h0000

`endif

/* File: hdl/iism_sync.v */
`timescale 1ns/1ps
`default_nettype none
`include "iism_defs.vh"

module iism_sync (
	// clock and reset
	input  wire        sys_clk_in,
	input  wire        rstn_in,
	// raw and synchronised levels
	input  wire [15:0] async_in,
	output reg  [15:0] sync_out
);

	reg [15:0] meta;

	// two flops; first stage feeds only the second
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta     <= 16'h0000;
			sync_out <= 16'h0000;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule // iism_sync
`default_nettype wire

/* File: testbench/iism_merge_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module iism_merge_monitor (
	// clock, reset and watched inputs
	input wire logic        sys_clk_in, rstn_in, floppy_act_in, floppy_irq_en_in,
	input wire logic        floppy_irq_in, kbd_act_in, kbd_irq_in,
	input wire logic [3:0]  floppy_irq_sel_in, kbd_irq_sel_in,
	input wire logic [15:0] gpio_irq_in, gpio_irq_func_in,
	// slot outputs
	input wire logic [15:0] slot_level_out, slot_claimed_out, slot_ext_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	wire fd = floppy_act_in && floppy_irq_sel_in == 4'h3;
	wire kb = kbd_irq_sel_in == 4'h5;
	chk_ext_exact: assert property ($past(rstn_in) |-> slot_ext_out ==
		($past(gpio_irq_func_in) & 16'h8EB8 & ~slot_claimed_out)) else $error("ext slots wrong");
	// three edges: two sync flops then the slot register
	chk_ext_synced: assert property (((slot_level_out ^ $past(gpio_irq_in, 3)) & slot_ext_out) == 0)
		else $error("gpio level not synced");
	chk_floppy_claim: assert property (fd && floppy_irq_en_in |=> slot_claimed_out[3]
		&& slot_level_out[3] == $past(floppy_irq_in)) else $error("floppy claim");
	chk_floppy_noen: assert property (fd && !floppy_irq_en_in && gpio_irq_func_in[3]
		|=> slot_ext_out[3]) else $error("disabled floppy blocks gpio");
	chk_floppy_inact: assert property (!floppy_act_in && floppy_irq_sel_in == 4'h3
		&& gpio_irq_func_in[3] |=> slot_ext_out[3]) else $error("inactive floppy blocks");
	chk_kbd_claim: assert property (kbd_act_in && kb |=> slot_claimed_out[5]
		&& slot_level_out[5] == $past(kbd_irq_in)) else $error("kbd claim");
	chk_kbd_inact: assert property (!kbd_act_in && kb && gpio_irq_func_in[5]
		|=> slot_ext_out[5]) else $error("inactive kbd blocks");
	chk_idle_quiet: assert property ((slot_level_out & ~(slot_ext_out | slot_claimed_out)) == 0)
		else $error("unowned slot driven");
	cover property (slot_claimed_out[3]);
	cover property (slot_ext_out[5] && slot_level_out[5]);
	cover property (slot_claimed_out == 16'h9EB0);
endmodule // iism_merge_monitor
bind iism_merge iism_merge_monitor u_mon (.*);
`default_nettype wire

/* File: testbench/iism_host.sv */
`timescale 1ns/1ps
`default_nettype none
module iism_host (
	input wire logic        sys_clk_in, rstn_in,
	input wire logic [15:0] slot_level_out,
	output logic     [15:0] frame_out
);
	// frame timing lives in the serialiser; sample every clock
	always_ff @(posedge sys_clk_in or negedge rstn_in) frame_out <= rstn_in ? slot_level_out : 16'h0;
endmodule // iism_host
`default_nettype wire

/* File: testbench/iism_merge_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module iism_merge_tb;
	logic sys_clk_in=0,rstn_in=0,floppy_act_in=0,uart1_act_in=0,uart2_act_in=0,uart3_act_in=0;
	logic par_act_in=0,kbd_act_in=0,midi_act_in=0,wdog_act_in=0,floppy_irq_en_in=0,uart1_irq_en_in=0;
	logic uart2_irq_en_in=0,uart3_irq_en_in=0,par_irq_en_in=0,floppy_irq_in=0,uart1_irq_in=0;
	logic uart2_irq_in=0,uart3_irq_in=0,par_irq_in=0,kbd_irq_in=0,mouse_irq_in=0,midi_irq_in=0;
	logic wdog_irq_in=0;
	logic [3:0] floppy_irq_sel_in=0,uart1_irq_sel_in=0,uart2_irq_sel_in=0,uart3_irq_sel_in=0;
	logic [3:0] par_irq_sel_in=0,kbd_irq_sel_in=0,mouse_irq_sel_in=0,midi_irq_sel_in=0;
	logic [3:0] watchdog_irq_config_in=0;
	logic [15:0] gpio_irq_in=0,gpio_irq_func_in=16'hFFFF,slot_level_out,slot_claimed_out;
	logic [15:0] slot_ext_out,frame,g;
	logic [47:0] e,q[$];
	int mismatches=0,tests_run=0,seed=32'hd9bb5bac;
	event chk;
	iism_merge i_iism_merge (.*);
	iism_host i_iism_host (.sys_clk_in,.rstn_in,.slot_level_out,.frame_out(frame));
	always #12.5 sys_clk_in = ~sys_clk_in;
	task cmp(input string n, input logic [15:0] s, x);
		tests_run++;
		if (s !== x) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", n, x, s);
		end
	endtask
	task give_verdict;
		if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// drive gpio, wait out the sync path, then note level, claim and ext and hand over
	task step(input logic [15:0] gi, lv, cl);
		gpio_irq_in = gi;
		repeat (4) @(posedge sys_clk_in);
		#1 q.push_back({lv, cl, gpio_irq_func_in & 16'h8EB8 & ~cl});
		->chk;
	endtask
	always @(chk) begin
		e = q.pop_front();
		cmp("level", frame, e[47:32]);
		cmp("claim", slot_claimed_out, e[31:16]);
		cmp("ext", slot_ext_out, e[15:0]);
	end
	initial begin
		#50000 mismatches++;
		give_verdict;
	end
	initial begin
		repeat (10) @(posedge sys_clk_in);
		#1 rstn_in = 1;
		repeat (16) begin
			g = 16'($random(seed));
			step(g, g & 16'h8EB8, 0);
		end
		gpio_irq_func_in = 0;
		step(16'hFFFF, 0, 0);
		gpio_irq_func_in = '1;
		{floppy_irq_sel_in, floppy_act_in, floppy_irq_en_in, floppy_irq_in} = 7'h1F;
		step(16'hFFF7, 16'h8EB8, 16'h8);
		floppy_irq_en_in = 0;
		step(16'h8, 16'h8, 0);
		{floppy_act_in, floppy_irq_en_in} = 2'b01;
		step(0, 0, 0);
		{kbd_irq_sel_in, kbd_act_in} = 5'hB;
		step(16'h20, 0, 16'h20);
		kbd_act_in = 0;
		step(16'h20, 16'h20, 0);
		{uart1_irq_sel_in, uart2_irq_sel_in, uart3_irq_sel_in, par_irq_sel_in} = 16'h7BF9;
		{mouse_irq_sel_in, midi_irq_sel_in, watchdog_irq_config_in} = 12'h4AC;
		{kbd_act_in, uart1_act_in, uart2_act_in, uart3_act_in, par_act_in, midi_act_in} = 6'h3F;
		{wdog_act_in, uart1_irq_en_in, uart2_irq_en_in, uart3_irq_en_in, par_irq_en_in} = 5'h1F;
		{uart1_irq_in, uart2_irq_in, uart3_irq_in, par_irq_in, mouse_irq_in, midi_irq_in,
			wdog_irq_in} = 7'h55;
		step(16'hFFFF, 16'h9098, 16'h9EB0);
		// let the checker take the last note before the run ends
		@(posedge sys_clk_in);
		give_verdict;
	end
endmodule // iism_merge_tb
`default_nettype wire
